// ---- agc_top.sv ----
// Purpose: AXI4-Lite control register bank for the gain amplifiers
// Assumes: One clock, synchronous active-low reset, one access at a time
// Notes: Decoded analog controls are registered one cycle after the word
//
// Contract
// - Route bit connects output to reference pin
// - Gain codes 2..6 give x4..x64
// - Bits seven to three read zero
// - Enable, route, positive, negative field layout
// - Positive codes 0..3 pick inputs one-four
// - Negative: ground, pin two, pin three
// - Channel n output goes to pin n
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "agc_params.svh"
module agc_top
  import agc_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [`AGC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`AGC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-channel analog controls
  output logic [NUM_CH-1:0] ampPowerDown,
  output logic [NUM_CH-1:0] ampPinRoute,
  output agc_pos_t [NUM_CH-1:0] ampPosSel,
  output agc_neg_t [NUM_CH-1:0] ampNegSel,
  output agc_gain_t [NUM_CH-1:0] ampGainSel
);

  // ==================================================================
  // Address helpers
  // Word index of a channel's control register
  function automatic logic [`AGC_ADDR_W-3:0] ctrlIdx(input int ch);
    logic [`AGC_ADDR_W-1:0] base;
    base = `AGC_CTRL_BASE;
    ctrlIdx = base[`AGC_ADDR_W-1:2] + (`AGC_ADDR_W-2)'(ch);
  endfunction : ctrlIdx

  // ==================================================================
  // Write path state
  // Held write address and its flag
  logic awHeld_ff;
  logic [`AGC_ADDR_W-1:0] awAddr_ff;
  // Held write data, strobes and flag
  logic wHeld_ff;
  logic [15:0] wData_ff;
  logic [1:0] wStrb_ff;
  // Response channel
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  // Both halves present, one write carried out
  logic doWrite;
  // Per-channel write hit
  logic [NUM_CH-1:0] wrHit;

  // ==================================================================
  // Read path state
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  // Read data chosen for the current address
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // ==================================================================
  // Register storage and decoder links
  agc_ctrl_t ctrlReg_ff [NUM_CH];
  // Writable bits; bits seven to three are never stored
  localparam agc_ctrl_t CtrlMask = `AGC_CTRL_WMASK;
  // Status view of every channel, four bits each
  logic [31:0] statusWord;

  // Accept each half only while not holding one and no answer pending;
  // this keeps one write in flight as the bus allows.
  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready = !wHeld_ff && !bvalid_ff;
  assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ==================================================================
  // Write address capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      // Released once the write is done
      awHeld_ff <= 1'b0;
    end
  end

  // ==================================================================
  // Write data capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 16'h0000;
      wStrb_ff <= 2'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      // Only the low half-word lands in the 16-bit registers
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata[15:0];
      wStrb_ff <= s_axi_wstrb[1:0];
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  // ==================================================================
  // Write response: OKAY for a control register, SLVERR elsewhere
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `AGC_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (|wrHit) ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==================================================================
  // Per-channel control register and decoder
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    agc_ctl_if cif ();
    assign wrHit[ch] = (awAddr_ff[`AGC_ADDR_W-1:2] == ctrlIdx(ch));

    // Byte lanes honoured; unimplemented bits never store
    always_ff @(posedge clk) begin
      if (!rstn) begin
        ctrlReg_ff[ch] <= `AGC_CTRL_RESET;
      end else if (doWrite && wrHit[ch]) begin
        if (wStrb_ff[0]) begin
          ctrlReg_ff[ch][7:0] <= wData_ff[7:0] & CtrlMask[7:0];
        end
        if (wStrb_ff[1]) begin
          ctrlReg_ff[ch][15:8] <= wData_ff[15:8];
        end
      end
    end

    // Word goes to the decoder; enable changes leave other fields alone
    assign cif.ctrlWord = ctrlReg_ff[ch];
    agc_decode u_dec (
      .clk (clk),
      .rstn (rstn),
      .cif (cif)
    );

    assign ampPinRoute[ch] = cif.pinRoute;
    assign ampPowerDown[ch] = cif.powerDown;
    assign ampPosSel[ch] = cif.posSel;
    assign ampNegSel[ch] = cif.negSel;
    assign ampGainSel[ch] = cif.gainSel;
    // Status nibble: reserved gain, pos, neg, then power-down
    assign statusWord[4*ch +: 4] = {cif.powerDown, cif.rsvNeg, cif.rsvPos,
      cif.rsvGain};

    // Route bit of channel n reaches pin n one cycle later
    chk_pin_map: assert property (@(posedge clk) disable iff (!rstn)
      ctrlReg_ff[ch][`AGC_ROUTE_BIT] |=> ampPinRoute[ch])
      else $error("channel route not on its own pin");
  end
  // Unused status bits read zero
  if (NUM_CH < 8) begin : g_stat_pad
    assign statusWord[31:4*NUM_CH] = '0;
  end

  // ==================================================================
  // Read selection
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `AGC_RESP_SLVERR;
    // Status word: read-only view of the decoder flags
    if (s_axi_araddr[`AGC_ADDR_W-1:2] == (`AGC_ADDR_W-2)'(`AGC_STAT_OFS >> 2)) begin
      nxt_rdata = statusWord;
      nxt_rresp = `AGC_RESP_OKAY;
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (s_axi_araddr[`AGC_ADDR_W-1:2] == ctrlIdx(ch)) begin
        nxt_rdata = {16'h0000, ctrlReg_ff[ch] & `AGC_CTRL_WMASK};
        nxt_rresp = `AGC_RESP_OKAY;
      end
    end
  end

  // ==================================================================
  // Read channel: answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `AGC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ==================================================================
  // Checks
  // All checks below run on clk and rest while reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // A full write to channel zero, then its stored word
  sequence seqWrCh0;
    doWrite && wrHit[0] && wStrb_ff == 2'h3;
  endsequence
  sequence seqStored;
    ctrlReg_ff[0] == ($past(wData_ff) & `AGC_CTRL_WMASK);
  endsequence

  // Full write to channel zero lands through the mask
  chk_write_store: assert property (
    seqWrCh0 |=> seqStored)
    else $error("control word not stored through mask");
  // Bits seven to three never hold a one
  chk_unimpl_store: assert property (
    ctrlReg_ff[0][7:3] == 5'h00 && ctrlReg_ff[NUM_CH-1][7:3] == 5'h00)
    else $error("unimplemented bits stored");
  // The response follows the write and blocks the next address
  chk_resp_follow: assert property (
    doWrite |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write response missing");
  // A read answer waits unchanged for rready
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  // Control word read back with its low reserved bits clear
  chk_read_zero: assert property (
    s_axi_arvalid && s_axi_arready
      && s_axi_araddr[`AGC_ADDR_W-1:2] == ctrlIdx(0)
      |=> s_axi_rvalid && s_axi_rdata[7:3] == 5'h00
        && s_axi_rdata[15:8] == $past(ctrlReg_ff[0][15:8]))
    else $error("read of control word wrong");
  // Enable high and no upper-lane write to channel zero this cycle
  sequence seqEnKept;
    ctrlReg_ff[0][`AGC_EN_BIT] && !(doWrite && wrHit[0] && wStrb_ff[1]);
  endsequence
  // Enable only falls through a write to its byte lane
  chk_enable_keep: assert property (
    seqEnKept |=> ctrlReg_ff[0][`AGC_EN_BIT])
    else $error("enable fell without a write");
  // Lane one alone leaves the gain field untouched
  chk_lane_keep: assert property (
    doWrite && wrHit[0] && wStrb_ff == 2'h2 |=> $stable(ctrlReg_ff[0][7:0]))
    else $error("low byte changed by a high-lane write");
  // Unmapped write answers with an error and stores nothing
  chk_write_refuse: assert property (
    doWrite && !(|wrHit) |=> s_axi_bresp == `AGC_RESP_SLVERR
      && $stable(ctrlReg_ff[0]) && $stable(ctrlReg_ff[NUM_CH-1]))
    else $error("unmapped write not refused");
  // Unmapped read answers with zero data and an error
  chk_read_refuse: assert property (
    s_axi_arvalid && s_axi_arready && nxt_rresp == `AGC_RESP_SLVERR
      |=> s_axi_rresp == `AGC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule : agc_top

// ---- agc_params.svh ----
// Purpose: Constants for the amplifier gain-control register bank
// Assumes: 32-bit AXI4-Lite bus, 12-bit byte address
// Notes: Offsets, field positions, reset values and codes live here only
`ifndef AGC_PARAMS_SVH
`define AGC_PARAMS_SVH

// ====================================================================
// Address map
`define AGC_ADDR_W 12
`define AGC_CTRL_BASE 12'h000
`define AGC_STAT_OFS 12'h010

// ====================================================================
// Control word layout
`define AGC_EN_BIT 15
`define AGC_ROUTE_BIT 14
`define AGC_POS_HI 13
`define AGC_POS_LO 11
`define AGC_NEG_HI 10
`define AGC_NEG_LO 8
`define AGC_GAIN_HI 2
`define AGC_GAIN_LO 0
`define AGC_CTRL_RESET 16'h0000
`define AGC_CTRL_WMASK 16'hFF07

// ====================================================================
// Field codes
`define AGC_GAIN_X4 3'h2
`define AGC_GAIN_X8 3'h3
`define AGC_GAIN_X16 3'h4
`define AGC_GAIN_X32 3'h5
`define AGC_GAIN_X64 3'h6
`define AGC_POS_LAST 3'h3
`define AGC_NEG_GND_A 3'h0
`define AGC_NEG_PIN2 3'h1
`define AGC_NEG_PIN3 3'h2
`define AGC_NEG_GND_B 3'h3

// ====================================================================
// Bus answers
`define AGC_RESP_OKAY 2'h0
`define AGC_RESP_SLVERR 2'h2

`endif

// ---- agc_pkg.sv ----
// Purpose: Shared types for the amplifier gain-control block
// Assumes: Constants come from agc_params.svh
// Notes: Types only
package agc_pkg;
  // Stored control word
  typedef logic [15:0] agc_ctrl_t;
  // One-hot gain: x4, x8, x16, x32, x64 from bit 0 up
  typedef logic [4:0] agc_gain_t;
  // One-hot positive input one to four
  typedef logic [3:0] agc_pos_t;
  // One-hot negative source: ground, pin two, pin three
  typedef logic [2:0] agc_neg_t;
endpackage : agc_pkg

// ---- agc_ctl_if.sv ----
// Purpose: Carrier between the register bank and one channel decoder
// Assumes: Single clock domain
// Notes: One instance per amplifier channel
`timescale 1ns/10ps
interface agc_ctl_if;
  import agc_pkg::*;
  // Stored control word
  agc_ctrl_t ctrlWord;
  // Decoded analog controls
  logic powerDown;
  logic pinRoute;
  agc_pos_t posSel;
  agc_neg_t negSel;
  agc_gain_t gainSel;
  // Reserved-code flags
  logic rsvGain;
  logic rsvPos;
  logic rsvNeg;
  modport regs (output ctrlWord, input powerDown, pinRoute, posSel, negSel,
    gainSel, rsvGain, rsvPos, rsvNeg);
  modport dec (input ctrlWord, output powerDown, pinRoute, posSel, negSel,
    gainSel, rsvGain, rsvPos, rsvNeg);
endinterface : agc_ctl_if

// ---- agc_decode.sv ----
// Purpose: Decode one control word into registered analog controls
// Assumes: Control word is stable logic on clk
// Notes: Reserved codes connect nothing and raise a flag
`timescale 1ns/10ps
`include "agc_params.svh"
module agc_decode
  import agc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control word in, decoded controls out
  agc_ctl_if.dec cif
);
  // Field views
  logic [2:0] posCode;
  logic [2:0] negCode;
  logic [2:0] gainCode;
  agc_pos_t nxt_pos;
  agc_gain_t nxt_gain;
  agc_neg_t nxt_neg;
  assign posCode = cif.ctrlWord[`AGC_POS_HI:`AGC_POS_LO];
  assign negCode = cif.ctrlWord[`AGC_NEG_HI:`AGC_NEG_LO];
  assign gainCode = cif.ctrlWord[`AGC_GAIN_HI:`AGC_GAIN_LO];

  // ==================================================================
  // Positive input one-hot, one line per input
  // positive input decode
  for (genvar i = 0; i < 4; i++) begin : g_pos
    assign nxt_pos[i] = (posCode == 3'(i));
  end

  // ==================================================================
  // Gain and negative source decode
  always_comb begin
    case (gainCode)
      `AGC_GAIN_X4: nxt_gain = 5'h01;
      `AGC_GAIN_X8: nxt_gain = 5'h02;
      `AGC_GAIN_X16: nxt_gain = 5'h04;
      `AGC_GAIN_X32: nxt_gain = 5'h08;
      `AGC_GAIN_X64: nxt_gain = 5'h10;
      default: nxt_gain = 5'h00;
    endcase
    case (negCode)
      `AGC_NEG_GND_A, `AGC_NEG_GND_B: nxt_neg = 3'h1;
      `AGC_NEG_PIN2: nxt_neg = 3'h2;
      `AGC_NEG_PIN3: nxt_neg = 3'h4;
      default: nxt_neg = 3'h0;
    endcase
  end

  // ==================================================================
  // Registered outputs keep the analog side glitch free
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cif.powerDown <= 1'b1;
      cif.pinRoute <= 1'b0;
      cif.posSel <= 4'h0;
      cif.negSel <= 3'h0;
      cif.gainSel <= 5'h00;
      cif.rsvGain <= 1'b0;
      cif.rsvPos <= 1'b0;
      cif.rsvNeg <= 1'b0;
    end else begin
      cif.powerDown <= ~cif.ctrlWord[`AGC_EN_BIT];
      cif.pinRoute <= cif.ctrlWord[`AGC_ROUTE_BIT];
      cif.posSel <= nxt_pos;
      cif.negSel <= nxt_neg;
      cif.gainSel <= nxt_gain;
      cif.rsvGain <= (nxt_gain == 5'h00);
      cif.rsvPos <= (posCode > `AGC_POS_LAST);
      cif.rsvNeg <= (nxt_neg == 3'h0);
    end
  end

  // ==================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_power_down: assert property (
    !cif.ctrlWord[`AGC_EN_BIT] |=> cif.powerDown)
    else $error("power-down not active while disabled");
  chk_route_pin: assert property (
    cif.ctrlWord[`AGC_ROUTE_BIT] |=> cif.pinRoute)
    else $error("route set but pin not connected");
  chk_route_off: assert property (
    !cif.ctrlWord[`AGC_ROUTE_BIT] |=> !cif.pinRoute)
    else $error("route clear but pin connected");
  chk_gain_x64: assert property (
    gainCode == `AGC_GAIN_X64 |=> cif.gainSel == 5'h10 && !cif.rsvGain)
    else $error("gain x64 decode wrong");
  chk_gain_x4: assert property (
    gainCode == `AGC_GAIN_X4 |=> cif.gainSel == 5'h01)
    else $error("gain x4 decode wrong");
  chk_pos_pick: assert property (
    posCode <= `AGC_POS_LAST |=> cif.posSel[$past(posCode[1:0])]
      && $onehot(cif.posSel))
    else $error("positive input decode wrong");
  chk_neg_ground: assert property (
    (negCode == `AGC_NEG_GND_A || negCode == `AGC_NEG_GND_B)
      |=> cif.negSel == 3'h1)
    else $error("negative ground decode wrong");
endmodule : agc_decode

// ---- testbench.sv ----
// Purpose: Self-checking bench for the amplifier gain-control register bank
// Assumes: NUM_CH is 2, control words at 0x000 and 0x004, status at 0x010
// Notes: Bus answers are checked from a queue of notes; amp outputs from a shadow copy
`timescale 1ns/10ps
`include "agc_params.svh"
module testbench
  import agc_pkg::*;
;
  // ==================================================================
  // Signals
  logic clk;
  logic rstn;
  logic [`AGC_ADDR_W-1:0] awAddr;
  logic [`AGC_ADDR_W-1:0] arAddr;
  logic awValid, wValid, bReady, arValid, rReady;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [1:0] powerDown, pinRoute;
  agc_pos_t [1:0] posSel;
  agc_neg_t [1:0] negSel;
  agc_gain_t [1:0] gainSel;
  // Bookkeeping
  int fail_count = 0;
  int checks_done = 0;
  integer seedVal = 56560;
  logic [15:0] shadow [2];
  logic [1:0] writeQ [$];
  logic [33:0] readQ [$];
  logic [33:0] rNote;
  logic [31:0] rnd;
  logic [31:0] d;
  int i;

  // ==================================================================
  // Design under test
  agc_top #(.NUM_CH(2)) dut (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .ampPowerDown(powerDown),
    .ampPinRoute(pinRoute), .ampPosSel(posSel), .ampNegSel(negSel),
    .ampGainSel(gainSel)
  );

  // Free-running 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ==================================================================
  // Expected decodes
  function automatic agc_gain_t exp_gain(input logic [2:0] g);
    return (g >= 3'h2 && g <= 3'h6) ? agc_gain_t'(5'h01 << (g - 3'h2)) : 5'h00;
  endfunction : exp_gain
  function automatic agc_pos_t exp_pos(input logic [2:0] p);
    return (p <= `AGC_POS_LAST) ? agc_pos_t'(4'h1 << p) : 4'h0;
  endfunction : exp_pos
  function automatic agc_neg_t exp_neg(input logic [2:0] n);
    case (n)
      3'h0, 3'h3: return 3'h1;
      3'h1: return 3'h2;
      3'h2: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction : exp_neg
  // Status nibble per channel: power-down, then reserved flags
  function automatic logic [31:0] exp_stat();
    logic [31:0] s;
    s = 32'h0;
    for (int c = 0; c < 2; c++) begin
      s[4*c+3] = ~shadow[c][15];
      s[4*c+2] = shadow[c][10:8] >= 3'h4;
      s[4*c+1] = shadow[c][13:11] >= 3'h4;
      s[4*c] = shadow[c][2:0] < 3'h2 || shadow[c][2:0] == 3'h7;
    end
    return s;
  endfunction : exp_stat

  // ==================================================================
  // Compare and verdict
  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    checks_done++;
    if (got !== expv) begin
      $display("mismatch %s expected %h seen %h", what, expv, got);
      fail_count++;
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ==================================================================
  // Bus master tasks; each releases a channel only at its handshake edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                           input logic [1:0] er);
    logic awDone, wDone, bDone;
    writeQ.push_back(er);
    awAddr <= a;
    wData <= v;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    awDone = 1'b0;
    wDone = 1'b0;
    bDone = 1'b0;
    // Only the watchdog ends a wait that never gets an answer
    while (!bDone) begin
      @(posedge clk);
      if (!awDone && awReady === 1'b1) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (!wDone && wReady === 1'b1) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
      if (bValid === 1'b1) bDone = 1'b1;
    end
    bReady <= 1'b0;
    // Shadow follows strobes; unimplemented bits never stored
    if (er == `AGC_RESP_OKAY) begin
      if (s[0]) shadow[a[2]][7:0] = v[7:0] & 8'h07;
      if (s[1]) shadow[a[2]][15:8] = v[15:8];
    end
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] expv, input logic [1:0] er);
    logic arDone, rDone;
    int stall;
    readQ.push_back({er, expv});
    arAddr <= a;
    arValid <= 1'b1;
    arDone = 1'b0;
    rDone = 1'b0;
    stall = $unsigned($random(seedVal)) % 3;
    while (!rDone) begin
      @(posedge clk);
      if (rValid === 1'b1 && rReady === 1'b1) rDone = 1'b1;
      else if (arDone) begin
        if (stall == 0) rReady <= 1'b1;
        else stall--;
      end
      if (!arDone && arReady === 1'b1) begin
        arDone = 1'b1;
        arValid <= 1'b0;
      end
    end
    rReady <= 1'b0;
    @(posedge clk);
  endtask : axi_read

  // Amp outputs against the shadow, sampled away from the edge
  task automatic check_amp;
    @(negedge clk);
    for (int c = 0; c < 2; c++) begin
      check("ampPowerDown", {31'h0, ~shadow[c][15]}, {31'h0, powerDown[c]});
      check("ampPinRoute", {31'h0, shadow[c][14]}, {31'h0, pinRoute[c]});
      check("ampGainSel", {27'h0, exp_gain(shadow[c][2:0])}, {27'h0, gainSel[c]});
      check("ampPosSel", {28'h0, exp_pos(shadow[c][13:11])}, {28'h0, posSel[c]});
      check("ampNegSel", {29'h0, exp_neg(shadow[c][10:8])}, {29'h0, negSel[c]});
    end
    @(posedge clk);
  endtask : check_amp

  // ==================================================================
  // Monitor: each answer takes the oldest note
  always @(posedge clk) begin
    if (bValid === 1'b1 && bReady === 1'b1) begin
      if (writeQ.size() == 0) check("write note", 32'h1, 32'h0);
      else check("bresp", {30'h0, writeQ.pop_front()}, {30'h0, bResp});
    end
    if (rValid === 1'b1 && rReady === 1'b1) begin
      if (readQ.size() == 0) check("read note", 32'h1, 32'h0);
      else begin
        rNote = readQ.pop_front();
        check("rdata", rNote[31:0], rData);
        check("rresp", {30'h0, rNote[33:32]}, {30'h0, rResp});
      end
    end
  end

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    fail_count++;
    results;
  end

  // ==================================================================
  // Main sequence
  initial begin
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    awAddr = 12'h000;
    arAddr = 12'h000;
    wData = 32'h0;
    wStrb = 4'h0;
    shadow[0] = `AGC_CTRL_RESET;
    shadow[1] = `AGC_CTRL_RESET;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values of both words and the status
    axi_read(12'h000, 32'h0, `AGC_RESP_OKAY);
    axi_read(12'h004, 32'h0, `AGC_RESP_OKAY);
    axi_read(`AGC_STAT_OFS, exp_stat(), `AGC_RESP_OKAY);
    check_amp;
    // Every code of every field, random enable, route, junk bits and strobes
    for (i = 0; i < 16; i++) begin
      rnd = $random(seedVal);
      d = rnd;
      d[13:11] = i[2:0];
      d[10:8] = i[2:0] ^ 3'h5;
      d[2:0] = i[2:0] + 3'h2;
      axi_write({9'h0, i[0], 2'h0}, d, (i < 8) ? 4'hF : rnd[19:16], `AGC_RESP_OKAY);
      check_amp;
      axi_read({9'h0, i[0], 2'h0}, {16'h0, shadow[i[0]]}, `AGC_RESP_OKAY);
      axi_read(`AGC_STAT_OFS, exp_stat(), `AGC_RESP_OKAY);
    end
    // Refused places leave state alone
    axi_write(12'h008, 32'hFFFFFFFF, 4'hF, `AGC_RESP_SLVERR);
    axi_write(`AGC_STAT_OFS, 32'hFFFFFFFF, 4'hF, `AGC_RESP_SLVERR);
    axi_read(12'h00C, 32'h0, `AGC_RESP_SLVERR);
    check_amp;
    // Second reset in mid-run clears the words
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    shadow[0] = `AGC_CTRL_RESET;
    shadow[1] = `AGC_CTRL_RESET;
    @(posedge clk);
    axi_read(12'h004, 32'h0, `AGC_RESP_OKAY);
    check_amp;
    results;
  end
endmodule : testbench
